/* File: lcio_pkg.sv */
package lcio_pkg;
  localparam int PIN_CNT = 35;
  localparam logic [15:0] CORE_REG_LO   = 16'h0000;
  localparam logic [15:0] CORE_REG_HI   = 16'h001f;
  localparam logic [15:0] IO_LO         = 16'h0020;
  localparam logic [15:0] IO_HI         = 16'h005f;
  localparam logic [15:0] EXT_IO_LO     = 16'h0060;
  localparam logic [15:0] EXT_IO_HI     = 16'h00ff;
  localparam logic [15:0] IO_INSTR_BASE = 16'h0020;
  localparam logic [15:0] RAM_BASE_NEW  = 16'h0100;
  localparam logic [15:0] RAM_BASE_OLD  = 16'h0060;
  localparam logic [15:0] RAM_SIZE      = 16'h0400;
  localparam logic [15:0] BAUD0_HI_ADDR = 16'h0040;
  localparam logic [15:0] BAUD1_HI_ADDR = 16'h003c;
  localparam logic [15:0] PCINT_LO      = 16'h006b;
  localparam logic [15:0] PCINT_HI      = 16'h006c;
  localparam logic [15:0] TMR2_FLAG_LO  = 16'h007c;
  localparam logic [15:0] TMR2_FLAG_HI  = 16'h007d;
  localparam logic [15:0] TMR2_LO       = 16'h0080;
  localparam logic [15:0] TMR2_HI       = 16'h008b;
  localparam logic [1:0]  FUSE_SETTLE   = 2'h2;
  localparam logic [PIN_CNT-1:0] JTAG_PU_MASK = 35'h0_00b0_0000;
  localparam logic [PIN_CNT-1:0] PIN_RST  = 35'h0_0000_0000;
endpackage

/* File: lcio_pin_if.sv */
`timescale 1ns/1ps
interface lcio_pin_if;
  logic [lcio_pkg::PIN_CNT-1:0] dir;
  logic [lcio_pkg::PIN_CNT-1:0] val;
  logic [lcio_pkg::PIN_CNT-1:0] pu_sel;
  modport ctl (output dir, output val, output pu_sel);
  modport pin (input dir, input val, input pu_sel);
endinterface

/* File: lcio_pin_ctl.sv */
`timescale 1ns/1ps
module lcio_pin_ctl (
  input  wire logic                         mclk_in,
  input  wire logic                         arst_n_in,
  lcio_pin_if.pin                           cfg,
  input  wire logic [lcio_pkg::PIN_CNT-1:0] pin_in,
  output logic      [lcio_pkg::PIN_CNT-1:0] pin_out,
  output logic      [lcio_pkg::PIN_CNT-1:0] pin_oe_out,
  output logic      [lcio_pkg::PIN_CNT-1:0] pin_pu_out,
  output logic      [lcio_pkg::PIN_CNT-1:0] pin_sync_out
);
  typedef struct packed {
    logic [lcio_pkg::PIN_CNT-1:0] s1;
    logic [lcio_pkg::PIN_CNT-1:0] s2;
    logic [lcio_pkg::PIN_CNT-1:0] drv;
    logic [lcio_pkg::PIN_CNT-1:0] oe;
    logic [lcio_pkg::PIN_CNT-1:0] pu;
  } lcio_pin_s;

  lcio_pin_s st_r;
  lcio_pin_s st_nxt;
  logic [lcio_pkg::PIN_CNT-1:0] pu_want;

  // per-bit pull-up only when the bit is an input
  genvar g;
  generate
    for (g = 0; g < lcio_pkg::PIN_CNT; g++) begin : g_pu
      assign pu_want[g] = ~cfg.dir[g] & cfg.pu_sel[g];
    end
  endgenerate

  always_comb begin
    st_nxt     = st_r;
    st_nxt.s1  = pin_in;
    st_nxt.s2  = st_r.s1;
    st_nxt.drv = cfg.val;
    st_nxt.oe  = cfg.dir;
    st_nxt.pu  = pu_want;
  end

  // asynchronous clear tri-states every pin without a clock
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= '{lcio_pkg::PIN_RST, lcio_pkg::PIN_RST, lcio_pkg::PIN_RST,
                lcio_pkg::PIN_RST, lcio_pkg::PIN_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin_out      = st_r.drv;
  assign pin_oe_out   = st_r.oe;
  assign pin_pu_out   = st_r.pu;
  assign pin_sync_out = st_r.s2;
endmodule

/* File: lcio_decode.sv */
`timescale 1ns/1ps
// What this block does
// - extended i/o 0x60..0xff reached only by load/store, never by i/o instructions
// - legacy i/o registers keep their old i/o addresses
// - compat fuse: extended region disabled, mapped as plain ram like predecessor
// - compat fuse: extended interrupt vectors removed
// - compat fuse: watchdog time-out change needs no timed sequence
// - compat fuse: serial receive double buffering disabled
// - compat fuse: pin-change interrupts unsupported
// - compat fuse: only first wide timer, second wide timer inaccessible
// - two baud high registers, addresses independent of the fuse
// - all port pins tri-stated during reset, clock or not
// - boundary-scan enabled: data-in, mode-select, test-clock pull-ups stay on in reset
// - reset held low long enough forces reset without a clock
// - four 8-bit and one 3-bit bidirectional ports, per-bit pull-ups
module lcio_decode (
  input  wire logic                         mclk_in,
  input  wire logic                         arst_n_in,
  input  wire logic                         legacy_compat_fuse_in,
  input  wire logic                         jtag_en_in,
  input  wire logic                         cpu_req_in,
  input  wire logic                         cpu_io_instr_in,
  input  wire logic [5:0]                   cpu_io_addr_in,
  input  wire logic [15:0]                  cpu_addr_in,
  input  wire logic                         cpu_we_in,
  input  wire logic [lcio_pkg::PIN_CNT-1:0] port_dir_in,
  input  wire logic [lcio_pkg::PIN_CNT-1:0] port_val_in,
  input  wire logic [lcio_pkg::PIN_CNT-1:0] port_pu_sel_in,
  input  wire logic [lcio_pkg::PIN_CNT-1:0] pin_in,
  output logic      [lcio_pkg::PIN_CNT-1:0] pin_out,
  output logic      [lcio_pkg::PIN_CNT-1:0] pin_oe_out,
  output logic      [lcio_pkg::PIN_CNT-1:0] pin_pu_out,
  output logic      [lcio_pkg::PIN_CNT-1:0] pin_sync_out,
  output logic                              ready_out,
  output logic                              acc_vld_out,
  output logic                              acc_we_out,
  output logic      [15:0]                  acc_addr_out,
  output logic      [15:0]                  ram_offset_out,
  output logic                              hit_core_out,
  output logic                              hit_io_out,
  output logic                              hit_ext_io_out,
  output logic                              hit_ram_out,
  output logic                              hit_xmem_out,
  output logic                              hit_serial0_baud_high_out,
  output logic                              hit_serial1_baud_high_out,
  output logic                              hit_pcint_out,
  output logic                              hit_second_wide_timer_out,
  output logic                              compat_mode_out,
  output logic                              ext_vectors_en_out,
  output logic                              wdt_timed_seq_en_out,
  output logic                              rx_double_buf_en_out,
  output logic                              pcint_en_out,
  output logic                              second_wide_timer_en_out
);
  typedef struct packed {
    logic [1:0]  fsync;
    logic [1:0]  settle;
    logic        ready;
    logic        fuse;
    logic        vld;
    logic        we;
    logic [15:0] addr;
    logic [15:0] roff;
    logic        h_core;
    logic        h_io;
    logic        h_ext;
    logic        h_ram;
    logic        h_xmem;
    logic        h_b0;
    logic        h_b1;
    logic        h_pc;
    logic        h_t2;
    logic        en;
  } lcio_dec_s;

  lcio_dec_s st_r;
  lcio_dec_s st_nxt;
  lcio_pin_if pif ();

  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  assign pif.dir    = port_dir_in;
  assign pif.val    = port_val_in;
  assign pif.pu_sel = port_pu_sel_in;

  logic [lcio_pkg::PIN_CNT-1:0] pu_reg;

  lcio_pin_ctl lcio_pin_ctl_i (
    .mclk_in      (mclk_in),
    .arst_n_in    (arst_n_in),
    .cfg          (pif.pin),
    .pin_in       (pin_in),
    .pin_out      (pin_out),
    .pin_oe_out   (pin_oe_out),
    .pin_pu_out   (pu_reg),
    .pin_sync_out (pin_sync_out)
  );

  // scan pull-ups bypass the reset-cleared flops
  assign pin_pu_out = pu_reg | (lcio_pkg::JTAG_PU_MASK & {lcio_pkg::PIN_CNT{jtag_en_in}});

  logic [15:0] eff_addr;
  logic [15:0] ram_base;
  logic        ext_rng;
  logic        ram_rng;

  always_comb begin
    st_nxt       = st_r;
    st_nxt.fsync = {st_r.fsync[0], legacy_compat_fuse_in};
    if (!st_r.ready) begin
      if (st_r.settle == lcio_pkg::FUSE_SETTLE) begin
        st_nxt.fuse  = st_r.fsync[1];
        st_nxt.ready = 1'b1;
      end else begin
        st_nxt.settle = st_r.settle + 2'h1;
      end
    end
    // i/o instructions only see the 64 legacy slots
    if (cpu_io_instr_in) begin
      eff_addr = lcio_pkg::IO_INSTR_BASE + {10'h000, cpu_io_addr_in};
    end else begin
      eff_addr = cpu_addr_in;
    end
    ram_base = st_r.fuse ? lcio_pkg::RAM_BASE_OLD : lcio_pkg::RAM_BASE_NEW;
    ext_rng  = in_rng(eff_addr, lcio_pkg::EXT_IO_LO, lcio_pkg::EXT_IO_HI);
    ram_rng  = (eff_addr >= ram_base) && (eff_addr < ram_base + lcio_pkg::RAM_SIZE);
    st_nxt.vld    = cpu_req_in & st_r.ready;
    st_nxt.we     = cpu_req_in & st_r.ready & cpu_we_in;
    st_nxt.addr   = eff_addr;
    st_nxt.roff   = eff_addr - ram_base;
    st_nxt.h_core = st_nxt.vld & in_rng(eff_addr, lcio_pkg::CORE_REG_LO, lcio_pkg::CORE_REG_HI);
    st_nxt.h_io   = st_nxt.vld & in_rng(eff_addr, lcio_pkg::IO_LO, lcio_pkg::IO_HI);
    st_nxt.h_ext  = st_nxt.vld & ext_rng & ~st_r.fuse;
    st_nxt.h_ram  = st_nxt.vld & ram_rng;
    st_nxt.h_xmem = st_nxt.vld & (eff_addr >= ram_base + lcio_pkg::RAM_SIZE);
    st_nxt.h_b0   = st_nxt.vld & (eff_addr == lcio_pkg::BAUD0_HI_ADDR);
    st_nxt.h_b1   = st_nxt.vld & (eff_addr == lcio_pkg::BAUD1_HI_ADDR);
    st_nxt.h_pc   = st_nxt.h_ext & in_rng(eff_addr, lcio_pkg::PCINT_LO, lcio_pkg::PCINT_HI);
    st_nxt.h_t2   = st_nxt.h_ext & (in_rng(eff_addr, lcio_pkg::TMR2_LO, lcio_pkg::TMR2_HI)
                    | in_rng(eff_addr, lcio_pkg::TMR2_FLAG_LO, lcio_pkg::TMR2_FLAG_HI));
    // native-only features, registered so the enables come from a flop
    st_nxt.en     = st_nxt.ready & ~st_nxt.fuse;
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ready_out                 = st_r.ready;
  assign acc_vld_out               = st_r.vld;
  assign acc_we_out                = st_r.we;
  assign acc_addr_out              = st_r.addr;
  assign ram_offset_out            = st_r.roff;
  assign hit_core_out              = st_r.h_core;
  assign hit_io_out                = st_r.h_io;
  assign hit_ext_io_out            = st_r.h_ext;
  assign hit_ram_out               = st_r.h_ram;
  assign hit_xmem_out              = st_r.h_xmem;
  assign hit_serial0_baud_high_out = st_r.h_b0;
  assign hit_serial1_baud_high_out = st_r.h_b1;
  assign hit_pcint_out             = st_r.h_pc;
  assign hit_second_wide_timer_out = st_r.h_t2;
  assign compat_mode_out           = st_r.fuse;
  assign ext_vectors_en_out        = st_r.en;
  assign wdt_timed_seq_en_out      = st_r.en;
  assign rx_double_buf_en_out      = st_r.en;
  assign pcint_en_out              = st_r.en;
  assign second_wide_timer_en_out  = st_r.en;
endmodule

/* File: lcio_decode_assertions.sv */
`timescale 1ns/1ps
module lcio_decode_chk (
  input wire logic        mclk_in,
  input wire logic        arst_n_in,
  input wire logic        jtag_en_in,
  input wire logic        cpu_req_in,
  input wire logic        cpu_io_instr_in,
  input wire logic [5:0]  cpu_io_addr_in,
  input wire logic [15:0] cpu_addr_in,
  input wire logic        ready_out,
  input wire logic        hit_ext_io_out,
  input wire logic        hit_ram_out,
  input wire logic        hit_pcint_out,
  input wire logic        hit_serial0_baud_high_out,
  input wire logic [15:0] ram_offset_out,
  input wire logic        compat_mode_out,
  input wire logic        ext_vectors_en_out,
  input wire logic [34:0] pin_oe_out,
  input wire logic [34:0] pin_pu_out
);
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!arst_n_in);
  logic tk;
  assign tk = cpu_req_in && ready_out;
  AST_IO_NO_EXT: assert property ($past(tk && cpu_io_instr_in) |-> !hit_ext_io_out)
    else $error("io instruction hit extended region");
  AST_EXT_HIT: assert property ($past(tk && !cpu_io_instr_in && cpu_addr_in inside {[16'h0060:16'h00ff]})
    && !compat_mode_out |-> hit_ext_io_out) else $error("extended region missed");
  AST_COMPAT_RAM: assert property (compat_mode_out |-> !hit_ext_io_out && !hit_pcint_out)
    else $error("extended function hit in compat mode");
  AST_COMPAT_OFS: assert property ($past(tk) && compat_mode_out && hit_ram_out |->
    ram_offset_out == ($past(cpu_io_instr_in) ? lcio_pkg::IO_INSTR_BASE + {10'h000, $past(cpu_io_addr_in)}
    : $past(cpu_addr_in)) - lcio_pkg::RAM_BASE_OLD) else $error("bad ram offset");
  AST_VECTORS: assert property (ext_vectors_en_out == (ready_out && !compat_mode_out))
    else $error("vector enable wrong");
  AST_TRISTATE: assert property ($rose(arst_n_in) |-> pin_oe_out == '0)
    else $error("pins driven out of reset");
  AST_FUSE_HOLD: assert property (ready_out |=> ready_out && $stable(compat_mode_out))
    else $error("map changed while running");
  AST_READY_LAT: assert property ($rose(arst_n_in) |-> !ready_out [*3] ##1 ready_out)
    else $error("ready timing wrong");
  AST_BAUD0: assert property ($past(tk && !cpu_io_instr_in && cpu_addr_in == lcio_pkg::BAUD0_HI_ADDR)
    |-> hit_serial0_baud_high_out) else $error("baud high missed");
  AST_JTAG_PU: assert property (disable iff (1'b0)
    jtag_en_in |-> (pin_pu_out & lcio_pkg::JTAG_PU_MASK) == lcio_pkg::JTAG_PU_MASK)
    else $error("scan pull-up off");
endmodule
bind lcio_decode lcio_decode_chk lcio_decode_chk_i (.*);

/* File: lcio_cpu_model.sv */
`timescale 1ns/1ps
module lcio_cpu_model (
  input  wire logic        mclk_in,
  output logic             req_out,
  output logic             io_out,
  output logic [5:0]       ioa_out,
  output logic [15:0]      addr_out
);
  initial begin
    req_out = 1'b0;
    io_out = 1'b0;
    ioa_out = 6'h00;
    addr_out = 16'h0000;
  end
  // one-cycle access, address lines scrambled after release
  task automatic acc(input logic io, input logic [15:0] a);
    @(posedge mclk_in);
    #1;
    req_out = 1'b1;
    io_out = io;
    ioa_out = a[5:0];
    addr_out = a;
    @(posedge mclk_in);
    #1;
    req_out = 1'b0;
    ioa_out = ~a[5:0];
    addr_out = ~a;
  endtask
endmodule

/* File: lcio_decode_tb.sv */
`timescale 1ns/1ps
module lcio_decode_tb;
  logic        mclk_in, arst_n_in, legacy_compat_fuse_in, jtag_en_in, cpu_req_in, cpu_io_instr_in, cpu_we_in;
  logic [5:0]  cpu_io_addr_in;
  logic [15:0] cpu_addr_in, acc_addr_out, ram_offset_out;
  logic [34:0] port_dir_in, port_val_in, port_pu_sel_in, pin_in, pin_out, pin_oe_out, pin_pu_out, pin_sync_out;
  logic        ready_out, acc_vld_out, acc_we_out, hit_core_out, hit_io_out, hit_ext_io_out, hit_ram_out;
  logic        hit_xmem_out, hit_serial0_baud_high_out, hit_serial1_baud_high_out, hit_pcint_out;
  logic        hit_second_wide_timer_out, compat_mode_out, ext_vectors_en_out, wdt_timed_seq_en_out;
  logic        rx_double_buf_en_out, pcint_en_out, second_wide_timer_en_out;
  int          error_cnt, checked;
  lcio_decode lcio_decode_i (.*);
  lcio_cpu_model lcio_cpu_model_i (.mclk_in(mclk_in), .req_out(cpu_req_in), .io_out(cpu_io_instr_in),
    .ioa_out(cpu_io_addr_in), .addr_out(cpu_addr_in));
  task automatic chk(input string nm, input logic [34:0] seen, input logic [34:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // hits: vld ext ram baud0 baud1 pcint timer2
  task automatic acc_chk(input logic io, input logic [15:0] a, input logic [6:0] exp);
    lcio_cpu_model_i.acc(io, a);
    chk("hits", {acc_vld_out, hit_ext_io_out, hit_ram_out, hit_serial0_baud_high_out,
      hit_serial1_baud_high_out, hit_pcint_out, hit_second_wide_timer_out}, exp);
  endtask
  task automatic do_reset(input logic fuse);
    @(posedge mclk_in);
    #1;
    arst_n_in = 1'b0;
    legacy_compat_fuse_in = fuse;
    #3;
    chk("oe_rst", pin_oe_out, '0);
    chk("pu_rst", pin_pu_out, jtag_en_in ? lcio_pkg::JTAG_PU_MASK : '0);
    repeat (4) @(posedge mclk_in);
    #1;
    arst_n_in = 1'b1;
    repeat (8) @(posedge mclk_in);
    #1;
    chk("compat", {ready_out, compat_mode_out}, {1'b1, fuse});
  endtask
  task automatic t_native;
    do_reset(1'b0);
    chk("enables", {ext_vectors_en_out, wdt_timed_seq_en_out, rx_double_buf_en_out, pcint_en_out,
      second_wide_timer_en_out}, 5'h1f);
    acc_chk(1'b0, 16'h0070, 7'h60);
    acc_chk(1'b1, 16'h003f, 7'h40);
    chk("io_map", {hit_io_out, hit_core_out, acc_addr_out}, {2'h2, 16'h005f});
    cpu_we_in = 1'b1;
    acc_chk(1'b0, 16'h0010, 7'h40);
    chk("core_we", {hit_core_out, hit_io_out, acc_we_out}, 3'h5);
    cpu_we_in = 1'b0;
    acc_chk(1'b1, 16'h0020, 7'h48);
    acc_chk(1'b0, 16'h003c, 7'h44);
    acc_chk(1'b0, 16'h006b, 7'h62);
    acc_chk(1'b0, 16'h0080, 7'h61);
    acc_chk(1'b0, 16'h04ff, 7'h50);
    chk("ofs", ram_offset_out, 16'h03ff);
    acc_chk(1'b0, 16'h0500, 7'h40);
    chk("xmem", {hit_xmem_out, hit_ram_out}, 2'h2);
  endtask
  task automatic t_compat;
    do_reset(1'b1);
    chk("enables", {ext_vectors_en_out, wdt_timed_seq_en_out, rx_double_buf_en_out, pcint_en_out,
      second_wide_timer_en_out}, 5'h00);
    acc_chk(1'b0, 16'h0070, 7'h50);
    chk("ofs", ram_offset_out, 16'h0010);
    acc_chk(1'b0, 16'h006b, 7'h50);
    acc_chk(1'b0, 16'h007c, 7'h50);
    acc_chk(1'b0, 16'h0040, 7'h48);
    acc_chk(1'b0, 16'h045f, 7'h50);
    acc_chk(1'b0, 16'h0460, 7'h40);
    chk("xmem_c", {hit_xmem_out, hit_ram_out}, 2'h2);
    legacy_compat_fuse_in = 1'b0;
    repeat (6) @(posedge mclk_in);
    #1;
    chk("fuse_hold", compat_mode_out, 1'b1);
  endtask
  task automatic t_pins;
    jtag_en_in = 1'b1;
    port_val_in = 35'h5_5555_5555;
    port_pu_sel_in = '1;
    pin_in = 35'h2_aaaa_aaaa;
    repeat (2) @(posedge mclk_in);
    #1;
    chk("pu", pin_pu_out, '1);
    chk("sync", pin_sync_out, 35'h2_aaaa_aaaa);
    port_dir_in = '1;
    @(posedge mclk_in);
    #1;
    chk("oe", pin_oe_out, '1);
    chk("out", pin_out, 35'h5_5555_5555);
    chk("pu_scan", pin_pu_out, lcio_pkg::JTAG_PU_MASK);
    do_reset(1'b0);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  initial begin
    error_cnt = 0;
    checked = 0;
    arst_n_in = 1'b0;
    legacy_compat_fuse_in = 1'b0;
    jtag_en_in = 1'b0;
    port_dir_in = '0;
    port_val_in = '0;
    port_pu_sel_in = '0;
    pin_in = '0;
    cpu_we_in = 1'b0;
    t_native;
    t_compat;
    t_pins;
    summarize;
  end
  initial begin
    #100000;
    error_cnt++;
    summarize;
  end
endmodule
